/* File: verilog/sabt_arbiter.sv */
// arbiter bit timer: counter, mode sequencer, wishbone slave and interrupt
// assumes one clock, receive and transmit signals synchronous to it
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "sabt_map.svh"

module sabt_arbiter #(
  parameter int CNT_W = 9
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // prescaler ticks and source choice
  input wire logic prescaler_bus_tick,
  input wire logic prescaler_osc_tick,
  input wire logic prescaler_source_select,
  // serial line
  input wire logic rxd,
  input wire logic transmitter_internal_out,
  output logic txd_pin,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------------
  // thresholds and the msb split assume the documented width
  if (CNT_W != 9) begin : g_bad_width
    $error("sabt_arbiter: CNT_W must be 9");
  end

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  wire req = cyc_i & stb_i;
  wire hit_ctrl = adr_i == `SABT_OFF_CTRL;
  wire hit_data = adr_i == `SABT_OFF_DATA;
  wire hit_stat = adr_i == `SABT_OFF_IRQ_STAT;
  wire hit_mask = adr_i == `SABT_OFF_IRQ_MASK;
  // writes and read side effects land on the edge that ends the cycle
  wire wr_fire = req & we_i & ack_q & sel_i[0];
  wire ctrl_wr = wr_fire & hit_ctrl;
  wire mask_wr = wr_fire & hit_mask;
  wire stat_rd = req & ~we_i & ack_q & hit_stat;

  // ----------------------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------------------
  sabt_pkg::sabt_state_e st_q, st_d;
  logic [1:0] mode_q;
  logic clk_sel_q;
  logic lost_q, done_q, ovf_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] div_q;
  logic half_q;
  logic rx_q, tx_q;
  logic rx_seen_q, sampled_q;
  logic txd_q;
  logic [2:0] irq_st_q, irq_mask_q;

  wire meas = mode_q == sabt_pkg::SABT_MODE_MEAS;
  wire arb = mode_q == sabt_pkg::SABT_MODE_ARB;
  wire running = st_q == sabt_pkg::SABT_ST_RUN;

  // one falling and one rising edge picker shared by both lines; prev is the level seen last cycle
  function automatic logic fell_edge(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic rose_edge(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // edges of the receive line and the transmitter output
  wire rx_fall = fell_edge(rx_q, rxd);
  wire rx_rise = rose_edge(rx_q, rxd);
  wire tx_rise = rose_edge(tx_q, transmitter_internal_out);
  wire tx_fall = fell_edge(tx_q, transmitter_internal_out);

  // ----------------------------------------------------------------------------
  // counter clock
  // ----------------------------------------------------------------------------
  // prescaler source mux lives here, the choosing bit lives outside
  wire presc_tick = prescaler_source_select ? prescaler_osc_tick
                                            : prescaler_bus_tick;
  wire bus_tick = div_q == 2'(`SABT_BUS_DIV - 1);
  // half rate of the prescaler: every second prescaler tick
  wire cnt_tick = clk_sel_q ? (presc_tick & half_q) : bus_tick;

  // compare value, picked per clock source
  wire [CNT_W-1:0] thr = clk_sel_q ? `SABT_THR_PRESC : `SABT_THR_BUS;

  // ----------------------------------------------------------------------------
  // events
  // ----------------------------------------------------------------------------
  // measurement start and stop conditions per clock source
  wire meas_start = clk_sel_q ? ~rxd : rx_fall;
  wire meas_stop = clk_sel_q ? rx_rise : rx_fall;
  // a flag event in the cycle of a control write still lands: set wins
  wire done_set = meas & running & meas_stop;
  // one static look at the receive line per bit
  wire sample_now = arb & running & ~sampled_q & (cnt_q == thr);
  wire lost_set = sample_now & ~rxd;
  wire carry = running & cnt_tick & (&cnt_q);
  wire ovf_set = carry;
  // transmitter low before a dominant receive bit aborts the bit
  wire arb_abort = arb & running & tx_fall & ~rx_seen_q & ~tx_rise;

  // ----------------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      sabt_pkg::SABT_ST_IDLE: begin
        cnt_d = '0;
      end
      sabt_pkg::SABT_ST_ARMED: begin
        if (meas && meas_start) begin
          st_d = sabt_pkg::SABT_ST_RUN;
          cnt_d = '0;
        end else if (arb && tx_rise) begin
          st_d = sabt_pkg::SABT_ST_RUN;
          cnt_d = '0;
        end
      end
      sabt_pkg::SABT_ST_RUN: begin
        if (meas && meas_stop) begin
          st_d = sabt_pkg::SABT_ST_DONE;
        end else if (arb && tx_rise) begin
          cnt_d = '0;
        end else if (arb_abort) begin
          st_d = sabt_pkg::SABT_ST_ARMED;
          cnt_d = '0;
        end else if (cnt_tick) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      sabt_pkg::SABT_ST_DONE: begin
        st_d = sabt_pkg::SABT_ST_DONE;
      end
      default: begin
        st_d = sabt_pkg::SABT_ST_IDLE;
      end
    endcase
    // mode 00 or the reserved code hold the counter in reset
    if (!meas && !arb) begin
      st_d = sabt_pkg::SABT_ST_IDLE;
      cnt_d = '0;
    end
    // a control write clears the count and rearms the chosen mode
    if (ctrl_wr) begin
      cnt_d = '0;
      st_d = sabt_pkg::SABT_ST_IDLE;
      if (dat_i[`SABT_BIT_MODE_HI] ^ dat_i[`SABT_BIT_MODE_LO]) begin
        st_d = sabt_pkg::SABT_ST_ARMED;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // sequencer and counter registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= sabt_pkg::SABT_ST_IDLE;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // divider, halver and edge history
  always_ff @(posedge clock) begin
    if (!rstn) begin
      div_q <= 2'h0;
      half_q <= 1'b0;
      rx_q <= 1'b1;
      tx_q <= 1'b1;
    end else begin
      div_q <= div_q + 2'h1;
      half_q <= half_q ^ presc_tick;
      rx_q <= rxd;
      tx_q <= transmitter_internal_out;
    end
  end

  // ----------------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------------
  // mode and clock select reset to idle on the bus clock divider
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_q <= 2'h0;
      clk_sel_q <= 1'b0;
    end else if (ctrl_wr) begin
      mode_q <= dat_i[`SABT_BIT_MODE_HI:`SABT_BIT_MODE_LO];
      clk_sel_q <= dat_i[`SABT_BIT_CLK_SEL];
    end
  end

  // status flags; a set in the cycle of a clear wins
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lost_q <= 1'b0;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      lost_q <= lost_set | (lost_q & ~(ctrl_wr & ~dat_i[`SABT_BIT_MODE_HI]));
      done_q <= done_set | (done_q & ~ctrl_wr);
      ovf_q <= ovf_set | (ovf_q & ~ctrl_wr);
    end
  end

  // per-bit arbitration bookkeeping, cleared at each bit start
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_seen_q <= 1'b0;
      sampled_q <= 1'b0;
    end else if (tx_rise || !arb || ctrl_wr) begin
      rx_seen_q <= 1'b0;
      sampled_q <= 1'b0;
    end else begin
      rx_seen_q <= rx_seen_q | ~rxd;
      sampled_q <= sampled_q | sample_now;
    end
  end

  // ----------------------------------------------------------------------------
  // transmit pin
  // ----------------------------------------------------------------------------
  // registered so the pin never glitches on the flag update
  always_ff @(posedge clock) begin
    if (!rstn) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= (lost_q | lost_set) | transmitter_internal_out;
    end
  end
  assign txd_pin = txd_q;

  // ----------------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------------
  wire [2:0] irq_ev = {ovf_set, lost_set, done_set};

  // a read clears only the bits it returned, so an event after the data was latched survives
  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_st_q <= 3'h0;
      irq_mask_q <= `SABT_RST_MASK;
    end else begin
      irq_st_q <= irq_ev | (irq_st_q & ~({3{stat_rd}} & dat_q[2:0]));
      if (mask_wr) begin
        irq_mask_q <= dat_i[2:0];
      end
    end
  end
  assign irq = |(irq_st_q & irq_mask_q);

  // ----------------------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------------------
  sabt_pkg::sabt_ctrl_s ctrl_img;
  assign ctrl_img = '{mode_hi: mode_q[1], mode_lo: mode_q[0], lost: lost_q,
                      clk_sel: clk_sel_q, done: done_q, running: running,
                      ovf: ovf_q, msb: cnt_q[CNT_W-1]};
  // unmapped words answer with zero and a normal ack
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_img} :
    hit_data ? {24'h000000, cnt_q[7:0]} :
    hit_stat ? {29'h0, irq_st_q} :
    hit_mask ? {29'h0, irq_mask_q} : 32'h00000000;

  // one wait state: ack the cycle after the strobe, drop it after
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) begin
        dat_q <= rd_mux;
      end
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_idle_holds_zero: assert property (
    (mode_q == 2'h0) && !ctrl_wr |=> (cnt_q == '0) && !running)
    else $error("counter not held in idle");

  a_lost_forces_tx: assert property (
    lost_q |=> txd_pin)
    else $error("transmit pin not forced high");

  a_ctrl_wr_clears: assert property (
    ctrl_wr |=> (cnt_q == '0) && (done_q == $past(done_set)) && (ovf_q == $past(ovf_set)))
    else $error("control write did not clear counter");

  a_meas_stop_done: assert property (
    done_set && !ctrl_wr |=> done_q && !running && (st_q == sabt_pkg::SABT_ST_DONE))
    else $error("measurement end not flagged");

  a_sample_sets_lost: assert property (
    sample_now && !rxd && !ctrl_wr |=> lost_q ##1 txd_pin)
    else $error("dominant bit not seen");

  a_lost_clear_hi: assert property (
    ctrl_wr && !dat_i[`SABT_BIT_MODE_HI] && !lost_set |=> !lost_q)
    else $error("lost flag survived clear");

  a_tx_rise_restart: assert property (
    arb && running && tx_rise && !ctrl_wr |=> (cnt_q == '0) && running)
    else $error("counter not restarted on transmit rise");

  a_abort_rearm: assert property (
    arb_abort && !ctrl_wr |=> (st_q == sabt_pkg::SABT_ST_ARMED) && (cnt_q == '0))
    else $error("abort did not reset counter");

  a_ovf_sticky: assert property (
    ovf_set |=> ovf_q [*2] or (ovf_q ##1 $past(ctrl_wr)))
    else $error("overflow flag not held");

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held for two cycles");

  a_count_step: assert property (
    running && cnt_tick && !ctrl_wr && !tx_rise && !arb_abort && !(meas && meas_stop)
    |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("counter did not advance on its tick");

  a_sample_once: assert property (
    sample_now |=> !sample_now)
    else $error("receive line sampled twice in one bit");

  a_meas_low_start: assert property (
    meas && clk_sel_q && (st_q == sabt_pkg::SABT_ST_ARMED) && !rxd && !ctrl_wr
    |=> running && (cnt_q == '0))
    else $error("low receive line did not start the count");

  a_txd_follows: assert property (
    !lost_q && !lost_set |=> txd_pin == $past(transmitter_internal_out))
    else $error("transmit pin did not follow the transmitter");

  a_stat_read_clears: assert property (
    stat_rd && (irq_ev == 3'h0) |=> (irq_st_q & $past(dat_q[2:0])) == 3'h0)
    else $error("status bits survived their read");

  a_ack_answers: assert property (
    req && !ack_o |=> ack_o)
    else $error("request not acknowledged after one wait state");

  c_meas_done: cover property (meas ##[1:1000] done_q);
  c_arb_lost: cover property (arb && tx_rise ##[1:300] lost_q);
  c_overflow: cover property (running ##[1:1000] ovf_q);
  c_irq_read: cover property (irq ##1 stat_rd);
  c_arb_abort: cover property (arb_abort);

endmodule

/* File: pkg/sabt_map.svh */
// offsets, field positions, reset values and counts of the arbiter bit timer
// assumes a 32-bit classic wishbone slave with word-aligned registers
//
// Overview of operation
// - a 9-bit up-counter with one overflow bit and start/stop/reset control
// - mode 00 idle with counter reset, 01 bit-time measure, 10 arbitrate, 11 reserved
// - reset clears both mode bits, so the block starts idle
// - read-only lost flag, cleared by writing 0 to upper mode bit or reset
// - clock select 1 uses half prescaler clock, 0 uses bus clock over four
// - prescaler runs from bus or oscillator clock per an outside configuration bit
// - read-only done flag set at measurement end, cleared by control write or reset
// - read-only running flag is 1 while counting, 0 when stopped
// - read-only overflow flag set on counter overflow, cleared by control write or reset
// - counter msb in control, low eight bits in data register; control write clears
// - counter held reset while both mode bits are zero
// - measure with select 0: run from one receive falling edge to the next
// - measure with select 1: run while receive low, stop on rising edge
// - arbitration restarts the counter on each transmitter output rising edge
// - at count 38h or 08h sample receive once; low sets lost flag
// - transmit pin forced high while lost flag is set
// - transmit low before receive seen low resets counter until next rising edge
`ifndef SABT_MAP_SVH
`define SABT_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SABT_OFF_CTRL 4'h0
`define SABT_OFF_DATA 4'h4
`define SABT_OFF_IRQ_STAT 4'h8
`define SABT_OFF_IRQ_MASK 4'hC

// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define SABT_BIT_MODE_HI 7
`define SABT_BIT_MODE_LO 6
`define SABT_BIT_CLK_SEL 4

// irq status bits
`define SABT_IRQ_DONE 0
`define SABT_IRQ_LOST 1
`define SABT_IRQ_OVF 2

// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define SABT_RST_CTRL 8'h00
`define SABT_RST_MASK 3'h0
`define SABT_BUS_DIV 4
`define SABT_THR_BUS 9'h038
`define SABT_THR_PRESC 9'h008

`endif

/* File: pkg/sabt_pkg.sv */
// types of the arbiter bit timer
// assumes sabt_map.svh carries all numeric constants
package sabt_pkg;

  // arbiter mode field encodings
  typedef enum logic [1:0] {
    SABT_MODE_IDLE = 2'h0,
    SABT_MODE_MEAS = 2'h1,
    SABT_MODE_ARB = 2'h2,
    SABT_MODE_RSVD = 2'h3
  } sabt_mode_e;

  // counter sequencer, gray along armed -> run -> done
  typedef enum logic [1:0] {
    SABT_ST_IDLE = 2'b00,
    SABT_ST_ARMED = 2'b01,
    SABT_ST_RUN = 2'b11,
    SABT_ST_DONE = 2'b10
  } sabt_state_e;

  // control register image
  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic lost;
    logic clk_sel;
    logic done;
    logic running;
    logic ovf;
    logic msb;
  } sabt_ctrl_s;

endpackage

/* File: sim/sabt_bus_node.sv */
// other node on the wired serial line, an open-drain driver beside the block
// assumes the line is pulled up and wired-and with the block's transmit pin
`timescale 1ns/1ps

module sabt_bus_node (
  // clock
  input wire logic clock,
  // line drive, low makes the line dominant
  output logic drive_n
);
  initial drive_n = 1'b1;

  // dominant for n cycles, then back to the pull-up level
  task automatic pull_low(input int n);
    @(posedge clock);
    drive_n <= 1'b0;
    repeat (n) @(posedge clock);
    drive_n <= 1'b1;
  endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench of the arbiter bit timer over classic wishbone
// assumes the partner node on the wired line and tick dividers made here
`timescale 1ns/1ps
`include "sabt_map.svh"

module tb;
  logic clock, rstn, cyc_i, stb_i, we_i, ack_o, txd_pin, irq, drive_n;
  logic rxd_q = 1'b1;
  logic [3:0] lanes = 4'hF;
  logic prescaler_bus_tick, prescaler_osc_tick, prescaler_source_select;
  logic transmitter_internal_out;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic rxd;
  int errors = 0, checked = 0, cnt = 0, t_f0 = 0, t_f1 = 0, t_r = 0;

  // wired line: pull-up, either party can make it dominant
  assign rxd = txd_pin & drive_n;

  sabt_arbiter dut_u (.clock(clock), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .prescaler_bus_tick(prescaler_bus_tick), .prescaler_osc_tick(prescaler_osc_tick),
    .prescaler_source_select(prescaler_source_select), .rxd(rxd),
    .transmitter_internal_out(transmitter_internal_out), .txd_pin(txd_pin), .irq(irq));
  sabt_bus_node node_u (.clock(clock), .drive_n(drive_n));

  // ---------------------------------------------------------------------------
  // clock, ticks and edge time stamps
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // bus ticks every 2 cycles, osc ticks every 4; stamps let counts ignore bus latency
  always @(posedge clock) begin
    cnt <= cnt + 1;
    prescaler_bus_tick <= (cnt % 2 == 1);
    prescaler_osc_tick <= (cnt % 4 == 3);
    rxd_q <= rxd;
    if (rxd_q && !rxd) begin
      t_f1 <= t_f0;
      t_f0 <= cnt;
    end
    if (!rxd_q && rxd) t_r <= cnt;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; held until ack is sampled, released at that edge
  // no cycle limit here: a missing ack is left to the watchdog
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    sel_i <= lanes;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    check("ack", ack_o, 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // measure between two falling edges, gap cycles apart, with clock select 0
  task automatic meas0(input int gap);
    int ticks, seen;
    logic ovf;
    wb(1'b1, `SABT_OFF_CTRL, 8'h40);
    node_u.pull_low(20);
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    check("running", rd[2], 1'b1);
    repeat (gap - 30) @(posedge clock);
    node_u.pull_low(20);
    repeat (4) @(posedge clock);
    ticks = (t_f0 - t_f1) / `SABT_BUS_DIV;
    ovf = (ticks > 511);
    wb(1'b0, `SABT_OFF_DATA, 8'h00);
    seen = rd[7:0];
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    seen = seen + (rd[0] << 8);
    check("count", (seen - ticks % 512) inside {-1, 0, 1}, 1'b1);
    check("done", rd[3:1], {1'b1, 1'b0, ovf});
    check("irq raised", irq, ovf);
    wb(1'b0, `SABT_OFF_IRQ_STAT, 8'h00);
    check("status", rd[2:0], {ovf, 2'b01});
    repeat (2) @(posedge clock);
    check("irq cleared", irq, 1'b0);
  endtask

  // break length with clock select 1; the line is already low when enabled
  task automatic meas1(input logic src);
    int t_w;
    int got;
    prescaler_source_select <= src;
    wb(1'b1, `SABT_OFF_CTRL, 8'h00);
    fork
      node_u.pull_low(300);
    join_none
    repeat (5) @(posedge clock);
    wb(1'b1, `SABT_OFF_CTRL, 8'h50);
    t_w = cnt;
    repeat (320) @(posedge clock);
    wb(1'b0, `SABT_OFF_DATA, 8'h00);
    // signed difference, so a count one short is not read as a huge number
    got = rd[7:0] - (t_r - t_w) / (src ? 8 : 4);
    check("break", got inside {[-2:2]}, 1'b1);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog well past the few thousand cycles the sequence needs
  initial begin
    #200000;
    errors++;
    final_report();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {cyc_i, stb_i, we_i, prescaler_source_select, adr_i, dat_i} = '0;
    sel_i = 4'hF;
    transmitter_internal_out = 1'b1;
    rstn = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    check("ctrl reset", rd, 32'h0);
    check("txd reset", txd_pin, 1'b1);
    wb(1'b1, 4'h2, 8'hFF);
    wb(1'b0, 4'h2, 8'h00);
    check("unmapped", rd, 32'h0);
    wb(1'b1, `SABT_OFF_CTRL, 8'h10);
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    check("clk sel rw", rd, 32'h10);
    // reserved mode keeps the counter idle across line activity
    wb(1'b1, `SABT_OFF_CTRL, 8'hC0);
    node_u.pull_low(20);
    node_u.pull_low(20);
    wb(1'b0, `SABT_OFF_DATA, 8'h00);
    check("idle count", rd, 32'h0);
    wb(1'b1, `SABT_OFF_IRQ_MASK, 8'h04);
    // a write without byte lane 0 leaves the register alone
    lanes = 4'hE;
    wb(1'b1, `SABT_OFF_IRQ_MASK, 8'h07);
    lanes = 4'hF;
    wb(1'b0, `SABT_OFF_IRQ_MASK, 8'h00);
    check("mask lane", rd, 32'h4);
    meas0(400);
    meas0(1200);
    meas0(2100);
    wb(1'b1, `SABT_OFF_CTRL, 8'h00);
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    check("ctrl write clears", rd, 32'h0);
    meas1(1'b0);
    meas1(1'b1);
    prescaler_source_select <= 1'b0;
    // dominant from 100 cycles after the rise: late for 08h, early for 38h
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, `SABT_OFF_CTRL, 8'h00);
      wb(1'b1, `SABT_OFF_CTRL, {3'b100, s[0], 4'h0});
      transmitter_internal_out <= 1'b0;
      repeat (4) @(posedge clock);
      transmitter_internal_out <= 1'b1;
      fork
        begin
          repeat (100) @(posedge clock);
          node_u.pull_low(200);
        end
      join_none
      repeat (320) @(posedge clock);
      wb(1'b0, `SABT_OFF_CTRL, 8'h00);
      check("lost", rd[5], s == 0);
      wb(1'b1, `SABT_OFF_CTRL, {3'b100, s[0], 4'h0});
      wb(1'b0, `SABT_OFF_CTRL, 8'h00);
      check("lost kept", rd[5], s == 0);
      transmitter_internal_out <= 1'b0;
      repeat (3) @(posedge clock);
      check("txd forced", txd_pin, s == 0);
      transmitter_internal_out <= 1'b1;
    end
    wb(1'b1, `SABT_OFF_CTRL, 8'h00);
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    check("lost cleared", rd[5], 1'b0);
    // transmitter falls with the line never seen low: bit aborted, rearmed on next rise
    wb(1'b1, `SABT_OFF_CTRL, 8'h80);
    transmitter_internal_out <= 1'b0;
    repeat (2) @(posedge clock);
    transmitter_internal_out <= 1'b1;
    repeat (20) @(posedge clock);
    transmitter_internal_out <= 1'b0;
    repeat (3) @(posedge clock);
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    check("abort stops", rd[2], 1'b0);
    wb(1'b0, `SABT_OFF_DATA, 8'h00);
    check("abort zeroes", rd, 32'h0);
    transmitter_internal_out <= 1'b1;
    repeat (8) @(posedge clock);
    wb(1'b0, `SABT_OFF_CTRL, 8'h00);
    check("rearm on rise", rd[2], 1'b1);
    final_report();
  end
endmodule
